// ---- psw_pkg.sv ----
/*
 * psw_pkg: constants, register map, field positions and types shared by
 * the pseudo-stop wake-up control and its clock quality checker.
 * Assumes a single 125 MHz system clock and an 8-bit register port.
 */
package psw_pkg;

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;

	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int unsigned CTRL_CME_BIT   = 0;
	localparam int unsigned CTRL_SELF_CLOCK_MODE_ENABLE_BIT  = 1;
	localparam int unsigned CTRL_SELF_CLOCK_IRQ_ENABLE_BIT = 2;
	localparam int unsigned CTRL_PSS_BIT   = 3;
	localparam int unsigned CTRL_LSEL_BIT  = 4;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

	// ---------------------------------------------------------------
	// status register fields
	// ---------------------------------------------------------------
	localparam int unsigned STAT_FLAG_BIT   = 0;
	localparam int unsigned STAT_BACKUP_BIT = 1;
	localparam int unsigned STAT_CAUSE_LSB  = 2;
	localparam int unsigned STAT_GOOD_BIT   = 4;
	localparam int unsigned STAT_STOP_BIT   = 5;
	localparam int unsigned STAT_RESET_BIT  = 6;

	// ---------------------------------------------------------------
	// wake causes
	// ---------------------------------------------------------------
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_EXT  = 2'h1;
	localparam logic [1:0] CAUSE_CM   = 2'h2;
	localparam logic [1:0] CAUSE_IRQ  = 2'h3;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned RESET_SEQ_NS     = 512;
	localparam int unsigned RESET_SEQ_CYCLES =
		(RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SEQ_W            = 7;
	localparam int unsigned QC_W             = 13;
	localparam logic [QC_W-1:0] QUAL_OSC_CYCLES = 13'h1000;

	typedef enum logic [2:0] {
		ST_RUN   = 3'h1,
		ST_STOP  = 3'h2,
		ST_RESET = 3'h4
	} psw_state_type;

endpackage : psw_pkg

// ---- psw_qc_if.sv ----
/*
 * psw_qc_if: signals between the wake-up control and its clock quality
 * checker. Assumes both ends run on the system clock.
 */
`timescale 1ns/10ps
interface psw_qc_if;
	logic start;
	logic osc_edge;
	logic fail;
	logic good;
	logic busy;

	modport ctrl (output start, output osc_edge, output fail, input good, input busy);
	modport chk  (input start, input osc_edge, input fail, output good, output busy);
endinterface : psw_qc_if

// ---- psw_qual_check.sv ----
/*
 * psw_qual_check: counts oscillator edges after a start request and
 * reports the clock as good once enough edges arrive without a failure.
 * Assumes osc_edge and fail are already synchronised to the system clock.
 */
`timescale 1ns/10ps
module psw_qual_check
	import psw_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// checker side
	psw_qc_if.chk     qc
);

	logic [QC_W-1:0] cnt_r;
	logic            busy_r;
	logic            good_r;

	// ---------------------------------------------------------------
	// edge counter, restarted by any failure
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			good_r <= 1'b0;
		end else begin
			good_r <= 1'b0;
			if (qc.start) begin
				cnt_r  <= '0;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (qc.fail) begin
					cnt_r <= '0;
				end else if (qc.osc_edge) begin
					if (cnt_r == QUAL_OSC_CYCLES - 13'h0001) begin
						cnt_r  <= '0;
						busy_r <= 1'b0;
						good_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r + 13'h0001;
					end
				end
			end
		end
	end

	assign qc.good = good_r;
	assign qc.busy = busy_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_good_after_count;
		@(posedge clk_in) disable iff (!rst_n_in)
		good_r |-> $past(cnt_r) == QUAL_OSC_CYCLES - 13'h0001 && !busy_r;
	endproperty
	a_good_after_count: assert property (p_good_after_count)
		else $error("quality good without full oscillator count");

endmodule : psw_qual_check

// ---- psw_wakeup_ctrl.sv ----
/*
 * psw_wakeup_ctrl: wake-up control for pseudo-stop. Handles external
 * reset, clock monitor failure and wake-up interrupts, runs the reset
 * sequence, backup clock mode and the forced return to the oscillator.
 * Assumes a core that pulses a stop request and reads the vector select
 * when the fetch strobe fires; oscillator, monitor and reset are pins.
 */
// Chosen here: the address-and-strobe port and the address map.
// Operation
// - External reset in pseudo-stop restores configuration defaults, starts reset generator.
// - After external reset sequence, fetch normal vector and return to run.
// - With monitoring enabled, detected clock loss lets the device leave pseudo-stop.
// - Clock failure without backup mode enabled issues the clock monitor reset.
// - Clock monitor reset runs the same sequence but selects another vector.
// - Backup mode and interrupt enabled: clock failure raises the backup-mode interrupt.
// - Then enter backup mode, start quality checker, resume normal operation.
// - Interrupt enable clear: flag still set, device stays in pseudo-stop.
// - Any other wake interrupt resumes normal operation immediately.
// - Loop-select is cleared; device runs on oscillator after leaving stop.
// - Monitoring disabled: clock loss in pseudo-stop is ignored.
// - Oscillator runs in stop only when pseudo-stop select is set.
// - Quality check reports good 4096 oscillator cycles after recovery.
// - Stop entered in backup mode keeps checking, loop and regulator enabled.
`timescale 1ns/10ps
module psw_wakeup_ctrl
	import psw_pkg::*;
(
	// clock and reset
	input  wire logic                      CLK_SYS_IN,
	input  wire logic                      RSTN_IN,
	// register port
	input  wire logic [psw_pkg::ADDR_W-1:0] REG_ADDR_IN,
	input  wire logic [psw_pkg::DATA_W-1:0] REG_WDATA_IN,
	input  wire logic                      REG_WR_IN,
	input  wire logic                      REG_RD_IN,
	output logic      [psw_pkg::DATA_W-1:0] REG_RDATA_OUT,
	// core side
	input  wire logic                      STOP_REQ_IN,
	input  wire logic                      WAKE_IRQ_IN,
	output logic                           FETCH_VECTOR_OUT,
	output logic                           VECTOR_SEL_OUT,
	output logic                           RESET_GEN_OUT,
	output logic                           SCM_IRQ_OUT,
	output logic                           STOP_ACTIVE_OUT,
	// pins
	input  wire logic                      EXT_RST_N_IN,
	input  wire logic                      CLK_MON_FAIL_IN,
	input  wire logic                      OSC_CLK_IN,
	// clock and power controls
	output logic                           OSC_ENABLE_OUT,
	output logic                           LOOP_ENABLE_OUT,
	output logic                           VOLTAGE_REGULATOR_ENABLE_OUT,
	output logic                           BACKUP_CLOCK_OUT,
	output logic                           LOOP_CLOCK_SEL_OUT
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	psw_state_type     state_r;
	psw_state_type     state_nxt;
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] rdata_r;
	logic              flag_r;
	logic              backup_r;
	logic              good_seen_r;
	logic [1:0]        cause_r;
	logic [1:0]        cause_nxt;
	logic [SEQ_W-1:0]  seq_cnt_r;
	logic              fetch_r;
	logic              ext_s1_r;
	logic              ext_s2_r;
	logic              fail_s1_r;
	logic              fail_s2_r;
	logic              osc_s1_r;
	logic              osc_s2_r;
	logic              osc_s3_r;
	logic              ext_rst;
	logic              cm_event;
	logic              scm_event;
	logic              seq_done;
	logic              wr_ctrl;
	logic              wr_stat;
	logic              qc_start;
	logic              clock_monitor_enable;
	logic              self_clock_mode_enable;
	logic              self_clock_irq_enable;
	logic              pss;

	psw_qc_if qc_bus ();

	assign clock_monitor_enable   = ctrl_r[CTRL_CME_BIT];
	assign self_clock_mode_enable  = ctrl_r[CTRL_SELF_CLOCK_MODE_ENABLE_BIT];
	assign self_clock_irq_enable = ctrl_r[CTRL_SELF_CLOCK_IRQ_ENABLE_BIT];
	assign pss   = ctrl_r[CTRL_PSS_BIT];

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			ext_s1_r  <= 1'b1;
			ext_s2_r  <= 1'b1;
			fail_s1_r <= 1'b0;
			fail_s2_r <= 1'b0;
			osc_s1_r  <= 1'b0;
			osc_s2_r  <= 1'b0;
			osc_s3_r  <= 1'b0;
		end else begin
			ext_s1_r  <= EXT_RST_N_IN;
			ext_s2_r  <= ext_s1_r;
			fail_s1_r <= CLK_MON_FAIL_IN;
			fail_s2_r <= fail_s1_r;
			osc_s1_r  <= OSC_CLK_IN;
			osc_s2_r  <= osc_s1_r;
			osc_s3_r  <= osc_s2_r;
		end
	end

	assign ext_rst = !ext_s2_r;

	// monitor failure only counts when enabled and oscillator is meant to run
	assign cm_event  = clock_monitor_enable && pss && fail_s2_r;
	assign scm_event = cm_event && self_clock_mode_enable && !backup_r;
	assign seq_done  = (seq_cnt_r == SEQ_W'(RESET_SEQ_CYCLES - 1)) && !ext_rst;

	// ---------------------------------------------------------------
	// state machine with cause priority
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		case (state_r)
			ST_RUN: begin
				if (ext_rst) begin
					state_nxt = ST_RESET;
					cause_nxt = CAUSE_EXT;
				end else if (STOP_REQ_IN) begin
					state_nxt = ST_STOP;
					cause_nxt = CAUSE_NONE;
				end
			end
			ST_STOP: begin
				if (ext_rst) begin
					state_nxt = ST_RESET;
					cause_nxt = CAUSE_EXT;
				end else if (cm_event && !self_clock_mode_enable) begin
					state_nxt = ST_RESET;
					cause_nxt = CAUSE_CM;
				end else if (scm_event && self_clock_irq_enable) begin
					state_nxt = ST_RUN;
					cause_nxt = CAUSE_CM;
				end else if (WAKE_IRQ_IN) begin
					state_nxt = ST_RUN;
					cause_nxt = CAUSE_IRQ;
				end
			end
			ST_RESET: begin
				if (ext_rst) begin
					cause_nxt = CAUSE_EXT;
				end else if (seq_done) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
				cause_nxt = CAUSE_NONE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			state_r <= ST_RUN;
			cause_r <= CAUSE_NONE;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
		end
	end

	// ---------------------------------------------------------------
	// reset generator
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			seq_cnt_r <= '0;
			fetch_r   <= 1'b0;
		end else begin
			fetch_r <= (state_r == ST_RESET) && seq_done;
			if (state_r != ST_RESET || ext_rst) begin
				seq_cnt_r <= '0;
			end else if (!seq_done) begin
				seq_cnt_r <= seq_cnt_r + SEQ_W'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == REG_CTRL);
	assign wr_stat = REG_WR_IN && (REG_ADDR_IN == REG_STAT);

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			ctrl_r <= CTRL_RESET;
		end else if (ext_rst || state_nxt == ST_RESET) begin
			ctrl_r <= CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= REG_WDATA_IN;
			end
			if (state_r == ST_RUN && STOP_REQ_IN) begin
				ctrl_r[CTRL_LSEL_BIT] <= 1'b0;
			end
		end
	end

	// interrupt flag: hardware set wins over write-one-to-clear
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			flag_r <= 1'b0;
		end else if (ext_rst || state_nxt == ST_RESET) begin
			flag_r <= 1'b0;
		end else if (state_r == ST_STOP && scm_event) begin
			flag_r <= 1'b1;
		end else if (wr_stat && REG_WDATA_IN[STAT_FLAG_BIT]) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			rdata_r <= '0;
		end else if (REG_RD_IN && REG_ADDR_IN == REG_CTRL) begin
			rdata_r <= ctrl_r;
		end else if (REG_RD_IN && REG_ADDR_IN == REG_STAT) begin
			rdata_r <= '0;
			rdata_r[STAT_FLAG_BIT]                  <= flag_r;
			rdata_r[STAT_BACKUP_BIT]                <= backup_r;
			rdata_r[STAT_CAUSE_LSB +: 2]            <= cause_r;
			rdata_r[STAT_GOOD_BIT]                  <= good_seen_r;
			rdata_r[STAT_STOP_BIT]                  <= state_r == ST_STOP;
			rdata_r[STAT_RESET_BIT]                 <= state_r == ST_RESET;
		end else begin
			rdata_r <= '0;
		end
	end

	// ---------------------------------------------------------------
	// backup clock mode and quality check
	// ---------------------------------------------------------------
	assign qc_start = state_r == ST_STOP && scm_event && !ext_rst;

	assign qc_bus.start    = qc_start;
	assign qc_bus.osc_edge = osc_s2_r && !osc_s3_r;
	assign qc_bus.fail     = fail_s2_r;

	psw_qual_check u_qual (
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (RSTN_IN),
		.qc       (qc_bus.chk)
	);

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RSTN_IN) begin
			backup_r    <= 1'b0;
			good_seen_r <= 1'b0;
		end else if (qc_start) begin
			backup_r    <= 1'b1;
			good_seen_r <= 1'b0;
		end else if (qc_bus.good) begin
			backup_r    <= 1'b0;
			good_seen_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign REG_RDATA_OUT      = rdata_r;
	assign FETCH_VECTOR_OUT   = fetch_r;
	assign VECTOR_SEL_OUT     = cause_r == CAUSE_CM;
	assign RESET_GEN_OUT      = state_r == ST_RESET;
	assign SCM_IRQ_OUT        = flag_r && self_clock_irq_enable;
	assign STOP_ACTIVE_OUT    = state_r == ST_STOP;
	assign OSC_ENABLE_OUT     = state_r != ST_STOP || pss;
	assign LOOP_ENABLE_OUT    = state_r != ST_STOP || backup_r;
	assign VOLTAGE_REGULATOR_ENABLE_OUT    = state_r != ST_STOP || backup_r;
	assign BACKUP_CLOCK_OUT   = backup_r;
	assign LOOP_CLOCK_SEL_OUT = ctrl_r[CTRL_LSEL_BIT] && !backup_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RSTN_IN);

	sequence s_stop_no_ext;
		state_r == ST_STOP && !ext_rst;
	endsequence

	sequence s_stop_cm;
		s_stop_no_ext ##0 cm_event;
	endsequence

	property p_ext_reset;
		state_r == ST_STOP && ext_rst |=> state_r == ST_RESET && cause_r == CAUSE_EXT
			&& ctrl_r == CTRL_RESET;
	endproperty
	a_ext_reset: assert property (p_ext_reset)
		else $error("external reset in stop not taken");

	property p_fetch_run;
		fetch_r |-> state_r == ST_RUN && $past(state_r) == ST_RESET;
	endproperty
	a_fetch_run: assert property (p_fetch_run)
		else $error("vector fetch outside end of reset sequence");

	property p_cm_reset;
		s_stop_cm ##0 !self_clock_mode_enable |=> state_r == ST_RESET && VECTOR_SEL_OUT;
	endproperty
	a_cm_reset: assert property (p_cm_reset)
		else $error("monitor failure did not start monitor reset");

	property p_scm_wake;
		s_stop_cm ##0 self_clock_mode_enable && self_clock_irq_enable && !backup_r |=> state_r == ST_RUN && flag_r
			&& backup_r && SCM_IRQ_OUT;
	endproperty
	a_scm_wake: assert property (p_scm_wake)
		else $error("backup mode wake not taken");

	property p_scm_stay;
		s_stop_cm ##0 self_clock_mode_enable && !self_clock_irq_enable && !backup_r |=> state_r == ST_STOP && flag_r;
	endproperty
	a_scm_stay: assert property (p_scm_stay)
		else $error("masked backup mode event woke the device");

	property p_irq_wake;
		s_stop_no_ext ##0 !cm_event && WAKE_IRQ_IN |=> state_r == ST_RUN
			&& cause_r == CAUSE_IRQ;
	endproperty
	a_irq_wake: assert property (p_irq_wake)
		else $error("wake interrupt did not resume run");

	property p_loop_cleared;
		state_r == ST_RUN && STOP_REQ_IN && !ext_rst |=> !LOOP_CLOCK_SEL_OUT [*2];
	endproperty
	a_loop_cleared: assert property (p_loop_cleared)
		else $error("loop select not cleared on stop entry");

	property p_cm_ignored;
		s_stop_no_ext ##0 !clock_monitor_enable && !WAKE_IRQ_IN |=> state_r == ST_STOP && !$rose(flag_r);
	endproperty
	a_cm_ignored: assert property (p_cm_ignored)
		else $error("disabled monitor caused an action");

	property p_osc_off;
		state_r == ST_STOP && !pss |-> !OSC_ENABLE_OUT;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator left running in full stop");

	property p_backup_power;
		state_r == ST_STOP && backup_r |-> LOOP_ENABLE_OUT && VOLTAGE_REGULATOR_ENABLE_OUT
			&& qc_bus.busy;
	endproperty
	a_backup_power: assert property (p_backup_power)
		else $error("loop or regulator off during backup mode check");

endmodule : psw_wakeup_ctrl

// ---- psw_osc_model.sv ----
/*
 * psw_osc_model: oscillator pin and clock monitor pin seen from outside.
 * Assumes the bench commands a clock loss; 32 ns period, over two system clocks.
 */
`timescale 1ns/10ps
module psw_osc_model (
	// control
	input  wire logic enable_in,
	input  wire logic lose_in,
	// pins
	output logic      osc_clk_out,
	output logic      mon_fail_out
);
	logic osc_r = 1'b0;

	// ---------------------------------------------------------------
	// oscillator
	// ---------------------------------------------------------------
	// stopped or disabled oscillator holds its pin low
	always begin
		#16;
		osc_r = (enable_in && !lose_in) ? ~osc_r : 1'b0;
	end
	assign osc_clk_out  = osc_r;
	assign mon_fail_out = lose_in;
endmodule : psw_osc_model

// ---- tb_top.sv ----
/*
 * tb_top: register-level tests of the pseudo-stop wake-up control.
 * Assumes the design's own assertions run beside it; 125 MHz clock.
 */
`timescale 1ns/10ps
module tb_top;
	import psw_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rst_n, wr, rd, stop_req, wake_irq, ext_rst_n, lose;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic              fetch, vsel, rgen, scm_irq, stop_act, osc, fail;
	logic              osc_en, loop_en, voltage_regulator_en, backup, lsel;
	int                error_cnt = 0;
	int                checks = 0;
	wire  [8:0]        obs = {fetch, vsel, rgen, scm_irq, stop_act, osc_en, loop_en, backup, lsel};

	always #4 clk_sys = ~clk_sys;

	psw_osc_model OSC (.enable_in(osc_en), .lose_in(lose), .osc_clk_out(osc), .mon_fail_out(fail));

	psw_wakeup_ctrl DUT (
		.CLK_SYS_IN(clk_sys), .RSTN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .STOP_REQ_IN(stop_req),
		.WAKE_IRQ_IN(wake_irq), .FETCH_VECTOR_OUT(fetch), .VECTOR_SEL_OUT(vsel),
		.RESET_GEN_OUT(rgen), .SCM_IRQ_OUT(scm_irq), .STOP_ACTIVE_OUT(stop_act),
		.EXT_RST_N_IN(ext_rst_n), .CLK_MON_FAIL_IN(fail), .OSC_CLK_IN(osc),
		.OSC_ENABLE_OUT(osc_en), .LOOP_ENABLE_OUT(loop_en), .VOLTAGE_REGULATOR_ENABLE_OUT(voltage_regulator_en),
		.BACKUP_CLOCK_OUT(backup), .LOOP_CLOCK_SEL_OUT(lsel)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// pins: vsel rgen scm stop osc_en loop_en backup lsel
	task automatic pin_chk(input string nm, input logic [7:0] mask, input logic [7:0] exp);
		chk(nm, obs[7:0] & mask, exp);
	endtask : pin_chk

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] mask,
			input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd   <= 1'b0;
		#1;
		chk(nm, rdata & mask, exp);
	endtask : rd_chk

	// one-cycle core request: 1 stop, 0 wake interrupt
	task automatic pulse(input logic is_stop);
		@(posedge clk_sys);
		stop_req <= is_stop;
		wake_irq <= !is_stop;
		@(posedge clk_sys);
		stop_req <= 1'b0;
		wake_irq <= 1'b0;
		#1;
	endtask : pulse

	task automatic wait_for(input int idx, input logic lvl, input int bound);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (obs[idx] !== lvl && n < bound);
		if (obs[idx] !== lvl) begin
			error_cnt++;
			$display("BAD wait on output %0d expected %b seen %b", idx, lvl, obs[idx]);
			complete_run();
		end
	endtask : wait_for

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		{rst_n, wr, rd, stop_req, wake_irq, lose} = 6'h00;
		ext_rst_n = 1'b1;
		addr      = 4'h0;
		wdata     = 8'h00;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		pin_chk("pins after reset", 8'hFF, 8'h0C);
		chk("voltage_regulator after reset", {7'h00, voltage_regulator_en}, 8'h01);
		rd_chk("ctrl reset", REG_CTRL, 8'hFF, CTRL_RESET);
		rd_chk("status reset", REG_STAT, 8'hFF, 8'h00);
		reg_wr(4'h8, 8'h5A);
		rd_chk("unmapped read", 4'h8, 8'hFF, 8'h00);
		$display("test reset done");

		reg_wr(REG_CTRL, 8'h19);
		rd_chk("ctrl written", REG_CTRL, 8'hFF, 8'h19);
		pin_chk("loop sel on", 8'h01, 8'h01);
		pulse(1'b1);
		pin_chk("pseudo stop pins", 8'h1F, 8'h18);
		rd_chk("loop sel cleared", REG_CTRL, 8'hFF, 8'h09);
		pulse(1'b0);
		pin_chk("woken by irq", 8'hFF, 8'h0C);
		rd_chk("cause irq", REG_STAT, 8'h0C, {CAUSE_IRQ, 2'h0});
		reg_wr(REG_CTRL, 8'h19);
		rd_chk("loop sel again", REG_CTRL, 8'hFF, 8'h19);
		pin_chk("loop clock back", 8'h01, 8'h01);
		reg_wr(REG_CTRL, 8'h01);
		pulse(1'b1);
		pin_chk("full stop osc off", 8'h18, 8'h10);
		pulse(1'b0);
		$display("test irq wake done");

		reg_wr(REG_CTRL, 8'h08);
		pulse(1'b1);
		lose <= 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		pin_chk("monitor off ignored", 8'hFF, 8'h18);
		rd_chk("no flag", REG_STAT, 8'h03, 8'h00);
		lose <= 1'b0;
		pulse(1'b0);
		$display("test monitor off done");

		reg_wr(REG_CTRL, 8'h09);
		pulse(1'b1);
		lose <= 1'b1;
		wait_for(6, 1'b1, 10);
		pin_chk("monitor reset", 8'hD0, 8'hC0);
		rd_chk("ctrl cleared", REG_CTRL, 8'hFF, CTRL_RESET);
		lose <= 1'b0;
		wait_for(8, 1'b1, 300);
		pin_chk("monitor vector", 8'hD0, 8'h80);
		rd_chk("cause monitor", REG_STAT, 8'h0C, {CAUSE_CM, 2'h0});
		$display("test monitor reset done");

		reg_wr(REG_CTRL, 8'h09);
		pulse(1'b1);
		ext_rst_n <= 1'b0;
		lose      <= 1'b1;
		wait_for(6, 1'b1, 10);
		pin_chk("ext wins", 8'hD0, 8'h40);
		rd_chk("defaults restored", REG_CTRL, 8'hFF, CTRL_RESET);
		lose <= 1'b0;
		repeat (4) @(posedge clk_sys);
		ext_rst_n <= 1'b1;
		wait_for(8, 1'b1, 300);
		pin_chk("normal vector", 8'hD0, 8'h00);
		rd_chk("cause ext", REG_STAT, 8'h0C, {CAUSE_EXT, 2'h0});
		$display("test external reset done");

		reg_wr(REG_CTRL, 8'h0F);
		pulse(1'b1);
		lose <= 1'b1;
		wait_for(5, 1'b1, 10);
		pin_chk("backup run", 8'h33, 8'h22);
		rd_chk("flag and backup", REG_STAT, 8'h03, 8'h03);
		lose <= 1'b0;
		repeat (16000) @(posedge clk_sys);
		#1;
		pin_chk("still checking", 8'h02, 8'h02);
		wait_for(1, 1'b0, 800);
		rd_chk("quality good", REG_STAT, 8'h12, 8'h10);
		reg_wr(REG_STAT, 8'h01);
		pin_chk("flag cleared", 8'h20, 8'h00);
		$display("test backup wake done");

		reg_wr(REG_CTRL, 8'h0B);
		pulse(1'b1);
		lose <= 1'b1;
		wait_for(1, 1'b1, 10);
		pin_chk("stays stopped", 8'h3E, 8'h1E);
		chk("voltage_regulator kept", {7'h00, voltage_regulator_en}, 8'h01);
		rd_chk("flag set", REG_STAT, 8'h01, 8'h01);
		lose <= 1'b0;
		pulse(1'b0);
		pin_chk("irq wake in backup", 8'h10, 8'h00);
		$display("test backup no irq done");
		complete_run();
	end
endmodule : tb_top
